// file: rtd_defines.svh
`ifndef RTD_DEFINES_SVH
`define RTD_DEFINES_SVH
`define RTD_OFF_CAP   5'h00
`define RTD_OFF_GCMD  5'h04
`define RTD_OFF_GSTS  5'h08
`define RTD_OFF_TINV  5'h0c
`define RTD_OFF_IADDR 5'h10
`define RTD_OFF_QDESC 5'h14
`define RTD_OFF_QSTAT 5'h18
`define RTD_OFF_OUTST 5'h1c
`define RTD_B_ENABLE  0
`define RTD_B_PEND    31
`define RTD_B_RDFL    27
`define RTD_B_WRFL    26
`define RTD_F_GRAN    29:28
`define RTD_F_QTYPE   19:16
`define RTD_F_DOM     15:0
`define RTD_F_MASK    5:0
`define RTD_PAGE_LSB  12
`define RTD_RST_WORD  32'h0000_0000
`endif

// file: rtd_pkg.sv
package rtd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EN   = 4'b0010,
    ST_REG  = 4'b0100,
    ST_Q    = 4'b1000
  } rtd_state_t;
  typedef enum logic [1:0] {
    GRAN_NONE   = 2'h0,
    GRAN_GLOBAL = 2'h1,
    GRAN_DOMAIN = 2'h2,
    GRAN_PAGE   = 2'h3
  } rtd_gran_t;
  typedef enum logic [1:0] {
    KIND_UNTR = 2'h0,
    KIND_XREQ = 2'h1,
    KIND_XLAT = 2'h2,
    KIND_RSVD = 2'h3
  } rtd_kind_t;
  typedef enum logic [3:0] {
    Q_NOP   = 4'h0,
    Q_IOTLB = 4'h1,
    Q_PASID = 4'h2,
    Q_WAIT  = 4'h3
  } rtd_qtype_t;
endpackage

// file: rtd_fill_guard.sv
`timescale 1ns/1ps
module rtd_fill_guard (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // walk result
  input  wire logic walk_valid_i,
  input  wire logic walk_present_i,
  input  wire logic walk_accessed_i,
  input  wire logic walk_leaf_i,
  input  wire logic walk_cached_i,
  // fill decisions
  output logic      fill_tlb_o,
  output logic      fill_psc_o,
  output logic      set_ad_o
);
  wire ok_fill = walk_valid_i & walk_present_i & walk_accessed_i; // RQ1 RQ2
  wire fresh   = walk_valid_i & walk_present_i & ~walk_cached_i;  // RQ3

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      fill_tlb_o <= 1'b0;
      fill_psc_o <= 1'b0;
      set_ad_o   <= 1'b0;
    end else begin
      fill_tlb_o <= ok_fill & walk_leaf_i;
      fill_psc_o <= ok_fill & ~walk_leaf_i; // RQ5
      set_ad_o   <= fresh; // RQ3
    end
  end
endmodule

// file: rtd_tracker.sv
`timescale 1ns/1ps
module rtd_tracker import rtd_pkg::*; #(
  parameter int N      = 8,
  parameter int IDX_W  = 3,
  parameter int DOM_W  = 16,
  parameter int PAGE_W = 20
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // allocation
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [DOM_W-1:0]  req_dom_i,
  input  wire logic [PAGE_W-1:0] req_page_i,
  output logic                   req_ready_o,
  output logic [IDX_W-1:0]       req_idx_o,
  // retirement
  input  wire logic              done_valid_i,
  input  wire logic [IDX_W-1:0]  done_idx_i,
  // drain request
  input  wire logic              drain_go_i,
  input  wire logic              drain_rd_i,
  input  wire logic              drain_wr_i,
  input  wire rtd_gran_t         drain_gran_i,
  input  wire logic [DOM_W-1:0]  drain_dom_i,
  input  wire logic [PAGE_W-1:0] drain_page_i,
  input  wire logic [5:0]        drain_mask_i,
  // state
  output logic                   drain_busy_o,
  output logic                   wr_pending_o,
  output logic [IDX_W:0]         count_o
);
  logic [N-1:0]      vld_r;
  logic [N-1:0]      wr_r;
  logic [N-1:0]      snap_r;
  logic [N-1:0]      hit;
  logic [DOM_W-1:0]  dom_r  [N];
  logic [PAGE_W-1:0] page_r [N];
  logic [IDX_W-1:0]  free_idx;
  logic              any_free;
  logic [IDX_W:0]    cnt;

  wire [PAGE_W-1:0] pmask = {PAGE_W{1'b1}} << drain_mask_i;

  always_comb begin
    free_idx = '0;
    any_free = 1'b0;
    cnt      = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (!vld_r[k]) begin
        free_idx = IDX_W'(k);
        any_free = 1'b1;
      end
      cnt = cnt + (IDX_W + 1)'(vld_r[k]);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ent
      wire dom_hit  = dom_r[gi] == drain_dom_i; // RQ20
      wire page_hit = ((page_r[gi] ^ drain_page_i) & pmask) == '0; // RQ21
      wire kind_hit = wr_r[gi] ? drain_wr_i : drain_rd_i; // RQ16
      wire sel_hit  = (drain_gran_i == GRAN_DOMAIN) ? dom_hit :
                      (drain_gran_i == GRAN_PAGE) ? (dom_hit & page_hit) : 1'b1; // RQ19
      wire alloc    = req_valid_i & any_free & (free_idx == IDX_W'(gi));
      wire retire   = done_valid_i & (done_idx_i == IDX_W'(gi)); // RQ9
      assign hit[gi] = vld_r[gi] & kind_hit & sel_hit;

      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          vld_r[gi]  <= 1'b0;
          snap_r[gi] <= 1'b0;
        end else begin
          if (alloc) begin
            vld_r[gi] <= 1'b1;
          end else if (retire) begin
            vld_r[gi] <= 1'b0;
          end
          snap_r[gi] <= drain_go_i ? (hit[gi] & ~retire) : (snap_r[gi] & ~retire & ~alloc);
        end
      end

      always_ff @(posedge clock_i) begin
        if (alloc) begin // RQ23
          dom_r[gi]  <= req_dom_i;
          page_r[gi] <= req_page_i;
          wr_r[gi]   <= req_write_i;
        end
      end
    end
  endgenerate

  assign req_ready_o  = any_free;
  assign req_idx_o    = free_idx;
  assign drain_busy_o = |(snap_r & vld_r);
  assign wr_pending_o = |(vld_r & wr_r);
  assign count_o      = cnt;
endmodule

// file: rtd_top.sv
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rtd_defines.svh"
// Contract
// RQ1: never fill from non-present paging entry
// RQ2: never fill from entry with accessed clear
// RQ3: cached use may skip accessed/dirty update
// RQ4: pending invalidation may use old or new
// RQ5: directory entries may be cached without leaves
// RQ6: software invalidates promptly for side-effect ranges
// RQ7: software keeps freed frames until invalidated
// RQ8: capability register advertises drain support
// RQ9: drained when visible or reads fully fetched
// RQ10: only memory-targeted requests are drained
// RQ11: only untranslated requests are drained
// RQ12: endpoint drains translated reads before completion
// RQ13: take ATS completion after writes drained
// RQ14: drain before raising remap on status
// RQ15: drain on disable is optional
// RQ16: read flag drains reads, write flag writes
// RQ17: register path drains before clearing pending
// RQ18: queued path drains before next wait
// RQ19: global drain covers every outstanding request
// RQ20: domain drain covers named domain only
// RQ21: page drain covers domain and overlapping range
// RQ22: PASID invalidation always drains both kinds
// RQ23: track domain, address, kind per request
module rtd_top import rtd_pkg::*; #(
  parameter int       N_ENTRIES = 8,
  parameter int       IDX_W     = 3,
  parameter int       DOM_W     = 16,
  parameter int       PAGE_W    = 20,
  parameter bit       RD_CAP    = 1'b1,
  parameter bit       WR_CAP    = 1'b1
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // avalon-mm slave
  input  wire logic [4:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // device requests after remapping
  input  wire logic              req_valid_i,
  input  wire logic [1:0]        req_kind_i,
  input  wire logic              req_mem_i,
  input  wire logic              req_write_i,
  input  wire logic [DOM_W-1:0]  req_dom_i,
  input  wire logic [PAGE_W-1:0] req_page_i,
  output logic                   req_ready_o,
  output logic [IDX_W-1:0]       req_idx_o,
  // memory commit
  input  wire logic              done_valid_i,
  input  wire logic [IDX_W-1:0]  done_idx_i,
  // ats invalidation completion
  input  wire logic              ats_cpl_valid_i,
  output logic                   ats_cpl_ready_o,
  output logic                   ats_cpl_taken_o,
  // page walk
  input  wire logic              walk_valid_i,
  input  wire logic              walk_present_i,
  input  wire logic              walk_accessed_i,
  input  wire logic              walk_leaf_i,
  input  wire logic              walk_cached_i,
  output logic                   fill_tlb_o,
  output logic                   fill_psc_o,
  output logic                   set_ad_o,
  // status
  output logic                   remap_on_o,
  output logic                   wait_done_o
);
  rtd_state_t     st_r;
  rtd_state_t     st_nxt;
  logic [31:0]    readdata_r;
  logic           rd_ack_r;
  logic           remap_on_r;
  logic           enable_r;
  logic           pend_r;
  logic [30:0]    tinv_r;
  logic [31:0]    iaddr_r;
  logic [31:0]    wait_cnt_r;
  logic           wait_done_r;
  logic           ats_taken_r;
  logic           drain_busy;
  logic           wr_pending;
  logic           trk_ready;
  logic [IDX_W:0] trk_count;

  // address decode
  wire sel_cap   = avs_address_i == `RTD_OFF_CAP;
  wire sel_gcmd  = avs_address_i == `RTD_OFF_GCMD;
  wire sel_gsts  = avs_address_i == `RTD_OFF_GSTS;
  wire sel_tinv  = avs_address_i == `RTD_OFF_TINV;
  wire sel_iaddr = avs_address_i == `RTD_OFF_IADDR;
  wire sel_qdesc = avs_address_i == `RTD_OFF_QDESC;
  wire sel_qstat = avs_address_i == `RTD_OFF_QSTAT;
  wire sel_outst = avs_address_i == `RTD_OFF_OUTST;
  wire is_idle   = st_r == ST_IDLE;

  // read and write handshake
  wire sel_cmd  = sel_gcmd | sel_tinv | sel_qdesc;
  wire wr_stall = avs_write_i & sel_cmd & ~is_idle;
  wire rd_wait  = avs_read_i & ~rd_ack_r;
  wire wr_acc   = avs_write_i & ~wr_stall;
  wire [31:0] wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] iaddr_m = (iaddr_r & ~wmask) | (avs_writedata_i & wmask);

  // command triggers
  wire        gcmd_wr  = wr_acc & sel_gcmd & avs_byteenable_i[0];
  wire        en_new   = avs_writedata_i[`RTD_B_ENABLE];
  wire        en_rise  = gcmd_wr & en_new & ~enable_r;
  wire        dis_fall = gcmd_wr & ~en_new & enable_r;
  wire        reg_trig = wr_acc & sel_tinv & avs_byteenable_i[3] &
                         avs_writedata_i[`RTD_B_PEND];
  wire        q_trig   = wr_acc & sel_qdesc & avs_byteenable_i[2];
  wire [3:0]  q_raw    = avs_writedata_i[`RTD_F_QTYPE];
  wire        q_iotlb  = q_trig & (q_raw == Q_IOTLB);
  wire        q_pasid  = q_trig & (q_raw == Q_PASID);
  wire        q_wait   = q_trig & (q_raw == Q_WAIT);
  wire        q_inv    = q_iotlb | q_pasid;
  wire        drain_go = is_idle & (en_rise | reg_trig | q_inv);

  // drain selection
  wire        sel_flags = reg_trig | q_iotlb;
  wire        d_rd   = en_rise | q_pasid | (sel_flags & avs_writedata_i[`RTD_B_RDFL]); // RQ16 RQ22
  wire        d_wr   = en_rise | q_pasid | (sel_flags & avs_writedata_i[`RTD_B_WRFL]); // RQ16 RQ22
  wire [1:0]  g_raw  = avs_writedata_i[`RTD_F_GRAN];
  wire rtd_gran_t d_gran = en_rise ? GRAN_GLOBAL : rtd_gran_t'(g_raw); // RQ14 RQ19
  wire [DOM_W-1:0]  d_dom  = avs_writedata_i[DOM_W-1:0];
  wire [PAGE_W-1:0] d_page = iaddr_r[`RTD_PAGE_LSB +: PAGE_W];
  wire [5:0]        d_mask = iaddr_r[`RTD_F_MASK];

  // only untranslated requests to memory are tracked
  wire trk_kind  = (req_kind_i == KIND_UNTR) & req_mem_i; // RQ10 RQ11
  wire trk_valid = req_valid_i & trk_kind;

  // read mux
  wire [31:0] cnt_word = {{(31 - IDX_W){1'b0}}, trk_count};
  wire [31:0] rd_mux =
    sel_cap   ? {30'h0, WR_CAP, RD_CAP} : // RQ8
    sel_gcmd  ? {31'h0, enable_r} :
    sel_gsts  ? {29'h0, wr_pending, ~is_idle, remap_on_r} :
    sel_tinv  ? {pend_r, tinv_r} :
    sel_iaddr ? iaddr_r :
    sel_qstat ? wait_cnt_r :
    sel_outst ? cnt_word :
    `RTD_RST_WORD;

  // fsm; translation is never stalled while a drain runs
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (en_rise) begin
          st_nxt = ST_EN;
        end else if (reg_trig) begin
          st_nxt = ST_REG;
        end else if (q_inv) begin
          st_nxt = ST_Q;
        end
      end
      ST_EN, ST_REG, ST_Q: begin
        if (!drain_busy) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // remap enable; disable skips draining
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      enable_r   <= 1'b0;
      remap_on_r <= 1'b0;
    end else begin
      if (gcmd_wr) begin
        enable_r <= en_new;
      end
      if (dis_fall) begin // RQ15
        remap_on_r <= 1'b0;
      end else if (st_r == ST_EN && !drain_busy) begin // RQ14
        remap_on_r <= 1'b1;
      end
    end
  end

  // register invalidate
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pend_r  <= 1'b0;
      tinv_r  <= '0;
      iaddr_r <= `RTD_RST_WORD;
    end else begin
      if (reg_trig) begin
        pend_r <= 1'b1;
        tinv_r <= avs_writedata_i[30:0];
      end else if (st_r == ST_REG && !drain_busy) begin // RQ17
        pend_r <= 1'b0;
      end
      if (wr_acc && sel_iaddr) begin
        iaddr_r <= iaddr_m;
      end
    end
  end

  // wait descriptor completes only while idle
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wait_done_r <= 1'b0;
      wait_cnt_r  <= '0;
      ats_taken_r <= 1'b0;
    end else begin
      wait_done_r <= q_wait; // RQ18
      if (q_wait) begin
        wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
      end
      ats_taken_r <= ats_cpl_valid_i & ats_cpl_ready_o;
    end
  end

  // bus read
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      readdata_r <= `RTD_RST_WORD;
      rd_ack_r   <= 1'b0;
    end else begin
      rd_ack_r <= rd_wait;
      if (rd_wait) begin
        readdata_r <= rd_mux;
      end
    end
  end

  rtd_tracker #(
    .N      (N_ENTRIES),
    .IDX_W  (IDX_W),
    .DOM_W  (DOM_W),
    .PAGE_W (PAGE_W)
  ) u_trk (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .req_valid_i  (trk_valid),
    .req_write_i  (req_write_i),
    .req_dom_i    (req_dom_i),
    .req_page_i   (req_page_i),
    .req_ready_o  (trk_ready),
    .req_idx_o    (req_idx_o),
    .done_valid_i (done_valid_i),
    .done_idx_i   (done_idx_i),
    .drain_go_i   (drain_go),
    .drain_rd_i   (d_rd),
    .drain_wr_i   (d_wr),
    .drain_gran_i (d_gran),
    .drain_dom_i  (d_dom),
    .drain_page_i (d_page),
    .drain_mask_i (d_mask),
    .drain_busy_o (drain_busy),
    .wr_pending_o (wr_pending),
    .count_o      (trk_count)
  );

  rtd_fill_guard u_fill (
    .clock_i         (clock_i),
    .nrst_i          (nrst_i),
    .walk_valid_i    (walk_valid_i),
    .walk_present_i  (walk_present_i),
    .walk_accessed_i (walk_accessed_i),
    .walk_leaf_i     (walk_leaf_i),
    .walk_cached_i   (walk_cached_i),
    .fill_tlb_o      (fill_tlb_o),
    .fill_psc_o      (fill_psc_o),
    .set_ad_o        (set_ad_o)
  );

  assign req_ready_o       = ~trk_kind | trk_ready; // RQ4
  assign ats_cpl_ready_o   = ~wr_pending; // RQ13
  assign ats_cpl_taken_o   = ats_taken_r;
  assign avs_readdata_o    = readdata_r;
  assign avs_waitrequest_o = rd_wait | wr_stall;
  assign remap_on_o        = remap_on_r;
  assign wait_done_o       = wait_done_r;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  property p_fill_present;
    (fill_tlb_o | fill_psc_o) |-> $past(walk_valid_i & walk_present_i);
  endproperty
  a_fill_present: assert property (p_fill_present) else $error("fill from absent entry"); // RQ1

  property p_fill_accessed;
    (fill_tlb_o | fill_psc_o) |-> $past(walk_accessed_i);
  endproperty
  a_fill_accessed: assert property (p_fill_accessed) else $error("fill with accessed clear"); // RQ2

  property p_ad_skip;
    walk_valid_i & walk_cached_i |=> !set_ad_o;
  endproperty
  a_ad_skip: assert property (p_ad_skip) else $error("update on cached use"); // RQ3

  property p_cap;
    avs_read_i & !avs_waitrequest_o & sel_cap |-> avs_readdata_o[1:0] == {WR_CAP, RD_CAP};
  endproperty
  a_cap: assert property (p_cap) else $error("capability mismatch"); // RQ8

  property p_ats;
    ats_cpl_taken_o |-> $past(!wr_pending);
  endproperty
  a_ats: assert property (p_ats) else $error("completion ahead of writes"); // RQ13

  property p_on_after_drain;
    $rose(remap_on_r) |-> $past(st_r == ST_EN) && !drain_busy;
  endproperty
  a_on_after_drain: assert property (p_on_after_drain) else $error("enabled before drain"); // RQ14

  property p_pend_clear;
    $fell(pend_r) |-> $past(st_r == ST_REG && !drain_busy);
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending cleared early"); // RQ17

  property p_wait;
    wait_done_o |-> $past(is_idle) ##0 $past(!drain_busy);
  endproperty
  a_wait: assert property (p_wait) else $error("wait done during drain"); // RQ18

  property p_pasid_both;
    q_pasid & is_idle |-> drain_go && d_rd && d_wr ##1 st_r == ST_Q;
  endproperty
  a_pasid_both: assert property (p_pasid_both) else $error("pasid drain incomplete"); // RQ22

  property p_untracked;
    req_valid_i & !trk_kind |=> trk_count <= $past(trk_count);
  endproperty
  a_untracked: assert property (p_untracked) else $error("translated request tracked"); // RQ11

  c_enable: cover property (st_r == ST_EN ##[1:20] $rose(remap_on_r));
  c_reg_inv: cover property (st_r == ST_REG && drain_busy ##[1:50] $fell(pend_r));
  c_wait: cover property (st_r == ST_Q ##[1:50] wait_done_o);
  c_ats: cover property (ats_cpl_valid_i && !ats_cpl_ready_o ##[1:50] ats_cpl_taken_o);
endmodule

// file: rtd_mem_model.sv
`timescale 1ns/1ps
module rtd_mem_model #(
  parameter int N     = 8,
  parameter int IDX_W = 3,
  parameter int LAT   = 2
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // tracked request taken
  input  wire logic             take_i,
  input  wire logic [IDX_W-1:0] take_idx_i,
  input  wire logic [N-1:0]     hold_i,
  // commit pulse
  output logic                  done_valid_o,
  output logic [IDX_W-1:0]      done_idx_o
);
  logic [N-1:0] busy_r;
  int           age_r [N];
  logic         fired;
  // one commit a cycle after a latency, none while held
  always @(posedge clock_i) begin
    fired = 1'b0;
    done_valid_o <= 1'b0;
    done_idx_o <= ~done_idx_o;
    if (!nrst_i) begin
      busy_r <= '0;
      done_idx_o <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        age_r[i] <= age_r[i] + 1;
        if (!fired && busy_r[i] && age_r[i] >= LAT && !hold_i[i]) begin
          fired = 1'b1;
          done_valid_o <= 1'b1;
          done_idx_o <= IDX_W'(i);
          busy_r[i] <= 1'b0;
        end
      end
      if (take_i) begin
        busy_r[take_idx_i] <= 1'b1;
        age_r[take_idx_i] <= 0;
      end
    end
  end
endmodule

// file: tb_rtd_top.sv
`timescale 1ns/1ps
`include "rtd_defines.svh"
module tb_rtd_top import rtd_pkg::*; ;
  typedef struct {int idx; int dom; int page; bit w;} rtd_ent_t;
  logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic        rv = 1'b0, rwr = 1'b0, rmem = 1'b0, rrdy, dv, av = 1'b0, ardy, atk;
  logic [1:0]  rkind = 2'h0;
  logic [15:0] rdom = 16'h0;
  logic [19:0] rpage = 20'h0;
  logic [2:0]  ridx, didx, dn_i;
  logic        wv = 1'b0, wp = 1'b0, wa = 1'b0, wl = 1'b0, wc = 1'b0;
  logic        ftlb, fpsc, sad, ron, wdone, tk_d = 1'b0, dn_d = 1'b0, at_d = 1'b0;
  logic [7:0]  hold = 8'hff;
  logic [4:0]  wq = 5'h00;
  integer      seed = 32'hb38b1390;
  int          err_total = 0, n_compared = 0, wait_cnt = 0, tk_cnt = 0;
  int          fi[$];
  int          cs[10] = '{8'h07, 8'h0b, 8'h0f, 8'h06, 8'h09, 8'h00, 8'h1b, 8'h1d, 8'h28, 8'h2c};
  rtd_ent_t    mq[$];
  rtd_ent_t    tk_e;
  wire         take = rv & rrdy & (rkind == 2'h0) & rmem;

  always #5 clk = ~clk;

  rtd_top u_rtd_top (.clock_i(clk), .nrst_i(nrst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .req_valid_i(rv), .req_kind_i(rkind),
    .req_mem_i(rmem), .req_write_i(rwr), .req_dom_i(rdom), .req_page_i(rpage),
    .req_ready_o(rrdy), .req_idx_o(ridx), .done_valid_i(dv), .done_idx_i(didx),
    .ats_cpl_valid_i(av), .ats_cpl_ready_o(ardy), .ats_cpl_taken_o(atk),
    .walk_valid_i(wv), .walk_present_i(wp), .walk_accessed_i(wa), .walk_leaf_i(wl),
    .walk_cached_i(wc), .fill_tlb_o(ftlb), .fill_psc_o(fpsc), .set_ad_o(sad),
    .remap_on_o(ron), .wait_done_o(wdone));

  rtd_mem_model #(.N(8), .IDX_W(3), .LAT(2)) u_rtd_mem_model (.clock_i(clk), .nrst_i(nrst),
    .take_i(take), .take_idx_i(ridx), .hold_i(hold), .done_valid_o(dv), .done_idx_o(didx));

  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      err_total++;
      end_of_test();
    end
  endtask

  function automatic bit has_wr();
    foreach (mq[k]) if (mq[k].w) return 1'b1;
    return 1'b0;
  endfunction

  function automatic bit hit(rtd_ent_t e, int g, bit fr, bit fw, int dm, int pg);
    if (!(e.w ? fw : fr)) return 1'b0;
    if (g >= 2 && e.dom != dm) return 1'b0;
    if (g == 3 && (e.page >> 2) != (pg >> 2)) return 1'b0;
    return 1'b1;
  endfunction

  // avalon master: hold until waitrequest seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (!wreq) break;
    end
    tmo(i, 400);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic send(input logic [1:0] k, input logic m, input logic w, input logic [15:0] dm,
                      input logic [19:0] pg);
    int i;
    @(posedge clk);
    rv <= 1'b1;
    rkind <= k;
    rmem <= m;
    rwr <= w;
    rdom <= dm;
    rpage <= pg;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (rrdy) break;
    end
    tmo(i, 50);
    rv <= 1'b0;
    rdom <= ~dm;
    rpage <= ~pg;
  endtask

  task automatic drain_all();
    int i;
    hold <= 8'h00;
    for (i = 0; i < 100; i++) begin
      bus(1'b0, `RTD_OFF_OUTST, 32'h0);
      if (got == 32'h0) break;
    end
    tmo(i, 100);
  endtask

  always @(posedge clk) if (nrst) {wv, wp, wa, wl, wc} <= 5'($random(seed));

  // model of the tracker, aligned to the design's registered view
  always @(negedge clk) begin
    if (tk_d) mq.push_back(tk_e);
    if (dn_d) begin
      fi = mq.find_first_index(e) with (e.idx == dn_i);
      if (fi.size() > 0) mq.delete(fi[0]);
    end
    tk_d = take;
    tk_e = '{int'(ridx), int'(rdom), int'(rpage), rwr};
    dn_d = dv;
    dn_i = didx;
    if (wdone) wait_cnt++;
    if (atk) tk_cnt++;
    chk("ats_ready", ardy, !has_wr());
    chk("ats_taken", atk, at_d);
    at_d = av & ardy;
    chk("fill", {ftlb, fpsc}, (wq[4] & wq[3] & wq[2]) ? {wq[1], !wq[1]} : 2'b00);
    chk("set_ad", sad, wq[4] & wq[3] & !wq[0]);
    wq = {wv, wp, wa, wl, wc};
  end

  initial begin
    int p, g, i, nw, w0;
    bit fr, fw;
    logic [7:0] mt;
    logic [15:0] da;
    logic [19:0] pgb;
    logic [31:0] cmd;
    nw = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, `RTD_OFF_CAP, 32'h0);
    chk("cap", got[1:0], 2'b11);
    bus(1'b1, 5'h02, 32'hffff_ffff);
    bus(1'b0, 5'h02, 32'h0);
    chk("unmapped", got, 32'h0);
    bus(1'b0, `RTD_OFF_GSTS, 32'h0);
    chk("gsts", got, 32'h0);
    // enable waits for drained tracked traffic
    for (i = 0; i < 3; i++) send(2'h0, 1'b1, 1'($random(seed)), 16'(i), 20'(i));
    bus(1'b1, `RTD_OFF_GCMD, 32'h1);
    repeat (6) @(posedge clk);
    chk("remap_on", ron, 1'b0);
    hold <= 8'h00;
    for (i = 0; i < 100 && ron !== 1'b1; i++) @(negedge clk);
    tmo(i, 100);
    chk("drained", mq.size(), 0);
    bus(1'b1, `RTD_OFF_GCMD, 32'h0);
    repeat (2) @(negedge clk);
    chk("remap_off", ron, 1'b0);
    for (int c = 0; c < 10; c++) begin
      p = cs[c] >> 4;
      g = (cs[c] >> 2) & 3;
      fr = cs[c][1] | (p == 2);
      fw = cs[c][0] | (p == 2);
      da = 16'($random(seed));
      pgb = {17'($random(seed)), 3'b000};
      hold <= 8'hff;
      for (int k = 0; k < 6; k++)
        send(2'h0, 1'b1, 1'($random(seed)), k[0] ? ~da : da, pgb + 20'($random(seed) & 7));
      for (int k = 1; k < 4; k++) send(2'(k), 1'b1, 1'b1, da, pgb);
      send(2'h0, 1'b0, 1'b1, da, pgb);
      bus(1'b0, `RTD_OFF_OUTST, 32'h0);
      chk("outstanding", got, 6);
      mt = 8'h00;
      foreach (mq[k]) if (hit(mq[k], g, fr, fw, da, pgb + 4)) mt[mq[k].idx] = 1'b1;
      bus(1'b1, `RTD_OFF_IADDR, {pgb + 20'h4, 12'h002});
      cmd = {p == 0, 1'b0, 2'(g), cs[c][1], cs[c][0], 6'h0, p == 2 ? Q_PASID : Q_IOTLB, da};
      bus(1'b1, p != 0 ? `RTD_OFF_QDESC : `RTD_OFF_TINV, cmd);
      repeat (8) @(posedge clk);
      bus(1'b0, `RTD_OFF_GSTS, 32'h0);
      chk("drain_busy", got[1], mt != 0);
      if (p == 0) begin
        bus(1'b0, `RTD_OFF_TINV, 32'h0);
        chk("pending", got[31], mt != 0);
        hold <= ~mt;
        for (i = 0; i < 100; i++) begin
          bus(1'b0, `RTD_OFF_TINV, 32'h0);
          if (got[31] === 1'b0) break;
        end
        tmo(i, 100);
      end else begin
        w0 = wait_cnt;
        fork
          bus(1'b1, `RTD_OFF_QDESC, {12'h0, Q_WAIT, 16'h0});
          begin
            repeat (10) @(posedge clk);
            chk("wait_early", wait_cnt - w0, mt == 0);
            hold <= ~mt;
          end
        join
        repeat (2) @(posedge clk);
        chk("wait_done", wait_cnt - w0, 1);
        nw++;
        bus(1'b0, `RTD_OFF_QSTAT, 32'h0);
        chk("wait_count", got, nw);
      end
      bus(1'b0, `RTD_OFF_OUTST, 32'h0);
      chk("left", got, 6 - $countones(mt));
      drain_all();
    end
    // completion held back while a tracked write is outstanding
    hold <= 8'hff;
    send(2'h0, 1'b1, 1'b1, 16'h0005, 20'h00005);
    av <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ats_early", tk_cnt, 0);
    hold <= 8'h00;
    for (i = 0; i < 50 && tk_cnt == 0; i++) @(posedge clk);
    tmo(i, 50);
    av <= 1'b0;
    drain_all();
    end_of_test();
  end
endmodule
